// file: core/hise_pkg.sv
package hise_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] FLAGS_OFS = 16'h0310;
  localparam logic [15:0] ENABLES_OFS = 16'h0314;
  localparam logic [31:0] FLAGS_RST = 32'h00000000;
  localparam logic [31:0] ENABLES_RST = 32'h00000000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ISO_BIT = 9;
  localparam int ASYNC_BIT = 8;
  localparam int INTL_BIT = 7;
  localparam int CLK_BIT = 6;
  localparam int SUSP_BIT = 5;
  localparam int DMA_BIT = 3;
  localparam int HOLD2_BIT = 2;
  localparam int SOF_BIT = 1;
  localparam int HOLD0_BIT = 0;

  // Bits that hardware sets and software may clear or enable.
  localparam logic [31:0] EVENT_BITS = 32'h000003EA;
  // Reserved bits that rise by themselves after reset.
  localparam logic [31:0] LATE_ONE_BITS = 32'h00000005;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ = 25000000;
  localparam int LATE_ONE_NS = 1000;
  localparam int LATE_ONE_CYC = (LATE_ONE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int WAKE_UNIT_US = 10;
  localparam int WAKE_UNIT_CYC = WAKE_UNIT_US * (CLK_HZ / 1000000);

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } hise_bus_s;

  typedef struct packed {
    logic [31:0] done;
    logic [31:0] and_mask;
    logic [31:0] or_mask;
  } hise_list_s;

  typedef struct packed {
    logic suspend_entered;
    logic dma_done;
    logic frame_start;
  } hise_evt_s;

endpackage

// file: core/hise_list_done.sv
`timescale 1ns/10ps
module hise_list_done #(
  parameter int N = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [N-1:0] done,
  input wire logic [N-1:0] and_mask,
  input wire logic [N-1:0] or_mask,
  output logic hit
);

  logic [N-1:0] seen_q;
  logic [N-1:0] seen_d;
  logic hit_d;
  logic [N-1:0] seen_now;

  // With no mask programmed every completion counts; otherwise the OR set
  // fires on any member and the AND set fires once all members are done.
  always_comb begin
    seen_now = seen_q | done;
    hit_d = 1'b0;
    seen_d = seen_now;
    if ((and_mask == '0) && (or_mask == '0)) begin
      hit_d = |done;
    end else begin
      if ((done & or_mask) != '0) begin
        hit_d = 1'b1;
      end
      if ((and_mask != '0) && ((seen_now & and_mask) == and_mask)) begin
        hit_d = 1'b1;
        seen_d = seen_now & ~and_mask;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      seen_q <= '0;
      hit <= 1'b0;
    end else begin
      seen_q <= seen_d;
      hit <= hit_d;
    end
  end

endmodule

// file: core/hise_wake_timer.sv
`timescale 1ns/10ps
module hise_wake_timer #(
  parameter int UNIT_CYC = hise_pkg::WAKE_UNIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [15:0] wake_time,
  output logic awake
);

  logic [15:0] units_q;
  logic [15:0] units_d;
  logic [15:0] pre_q;
  logic [15:0] pre_d;

  // A zero wake time means the controller never wakes.
  always_comb begin
    units_d = units_q;
    pre_d = pre_q;
    if (start) begin
      units_d = wake_time;
      pre_d = 16'(UNIT_CYC - 1);
    end else if (units_q != 16'h0000) begin
      if (pre_q == 16'h0000) begin
        pre_d = 16'(UNIT_CYC - 1);
        units_d = units_q - 16'h0001;
      end else begin
        pre_d = pre_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      units_q <= 16'h0000;
      pre_q <= 16'h0000;
      awake <= 1'b0;
    end else begin
      units_q <= units_d;
      pre_q <= pre_d;
      awake <= (units_d != 16'h0000);
    end
  end

endmodule

// file: core/hise_top.sv
// Behaviour
// - Writing one clears a status flag.
// - Flags latch regardless of master gate.
// - Bit 9 sets on isochronous completion.
// - Bit 8 sets on asynchronous completion.
// - Bit 7 sets on interrupt-list completion.
// - Bit 6 sets when clocks stable.
// - Bit 5 sets on suspend entry.
// - Access after suspend wakes for programmed time.
// - Bit 3 sets on DMA completion.
// - Bit 1 sets on start of frame.
// - Bits 2,0 read zero, then one.
// - IRQ needs matching enable bit set.
// - Enables 9,8,7 gate list completions.
// - Enable 6 gates clock-stable IRQ.
// - Enable 5 gates suspend IRQ.
// - Enable 3 gates DMA IRQ.
// - Enable 1 gates start-of-frame IRQ.
// - Masks select AND/OR over 32 descriptors.
// - Clock-ready raised when clocks restart.
`timescale 1ns/10ps
module hise_top #(
  parameter int DESC_N = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input hise_pkg::hise_bus_s bus,
  input hise_pkg::hise_list_s iso_list,
  input hise_pkg::hise_list_s async_list,
  input hise_pkg::hise_list_s intl_list,
  input hise_pkg::hise_evt_s evt,
  input wire logic clocks_running,
  input wire logic master_irq_gate,
  input wire logic [15:0] wake_time,
  output logic [31:0] rdata,
  output logic irq,
  output logic wake_hold
);

  // ************************************************************
  // Completion detectors
  // ************************************************************
  logic iso_hit;
  logic async_hit;
  logic intl_hit;

  // Each list keeps its own partial AND set, so the three never interfere.
  hise_list_done #(.N(DESC_N)) u_iso (
    .clk(clk),
    .nrst(nrst),
    .done(iso_list.done[DESC_N-1:0]),
    .and_mask(iso_list.and_mask[DESC_N-1:0]),
    .or_mask(iso_list.or_mask[DESC_N-1:0]),
    .hit(iso_hit)
  );

  hise_list_done #(.N(DESC_N)) u_async (
    .clk(clk),
    .nrst(nrst),
    .done(async_list.done[DESC_N-1:0]),
    .and_mask(async_list.and_mask[DESC_N-1:0]),
    .or_mask(async_list.or_mask[DESC_N-1:0]),
    .hit(async_hit)
  );

  hise_list_done #(.N(DESC_N)) u_intl (
    .clk(clk),
    .nrst(nrst),
    .done(intl_list.done[DESC_N-1:0]),
    .and_mask(intl_list.and_mask[DESC_N-1:0]),
    .or_mask(intl_list.or_mask[DESC_N-1:0]),
    .hit(intl_hit)
  );

  // ************************************************************
  // Clock-stable input crossing
  // ************************************************************
  // The clock-ready level comes from the clock generator, outside this domain.
  // Only the second stage feeds logic, because the first may still be settling.
  logic clk_meta_q;
  logic clk_meta_d;
  logic clk_sync_q;
  logic clk_sync_d;
  logic clk_prev_q;
  logic clk_prev_d;
  logic clk_rise;

  always_comb begin
    clk_meta_d = clocks_running;
    clk_sync_d = clk_meta_q;
    clk_prev_d = clk_sync_q;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      clk_meta_q <= 1'b0;
      clk_sync_q <= 1'b0;
      clk_prev_q <= 1'b0;
    end else begin
      clk_meta_q <= clk_meta_d;
      clk_sync_q <= clk_sync_d;
      clk_prev_q <= clk_prev_d;
    end
  end

  // A level that is already high out of reset also counts as one event.
  assign clk_rise = clk_sync_q & ~clk_prev_q;

  // ************************************************************
  // Late-rising reserved bits
  // ************************************************************
  // The counter saturates, so it never wraps and the late bits stay up for good.
  localparam logic [7:0] LATE_CNT = 8'(hise_pkg::LATE_ONE_CYC);
  logic [7:0] late_q;
  logic [7:0] late_d;

  always_comb begin
    late_d = late_q;
    if (late_q != LATE_CNT) begin
      late_d = late_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      late_q <= 8'h00;
    end else begin
      late_q <= late_d;
    end
  end

  // ************************************************************
  // Register decode
  // ************************************************************
  logic wr_flags;
  logic wr_enables;
  logic rd_flags;
  logic rd_enables;

  // Both strobes qualify on the select, so a stray read or write alone is ignored.
  always_comb begin
    wr_flags = 1'b0;
    wr_enables = 1'b0;
    rd_flags = 1'b0;
    rd_enables = 1'b0;
    if (bus.sel) begin
      if (bus.addr == hise_pkg::FLAGS_OFS) begin
        wr_flags = bus.wr;
        rd_flags = bus.rd;
      end else if (bus.addr == hise_pkg::ENABLES_OFS) begin
        wr_enables = bus.wr;
        rd_enables = bus.rd;
      end
    end
  end

  // ************************************************************
  // Event sources
  // ************************************************************
  logic [31:0] set_vec;

  // Events latch whatever the master gate says.
  always_comb begin
    set_vec = 32'h00000000;
    set_vec[hise_pkg::ISO_BIT] = iso_hit;
    set_vec[hise_pkg::ASYNC_BIT] = async_hit;
    set_vec[hise_pkg::INTL_BIT] = intl_hit;
    set_vec[hise_pkg::CLK_BIT] = clk_rise;
    set_vec[hise_pkg::SUSP_BIT] = evt.suspend_entered;
    set_vec[hise_pkg::DMA_BIT] = evt.dma_done;
    set_vec[hise_pkg::SOF_BIT] = evt.frame_start;
    // The late bits are set again every cycle, which keeps them immune to clears.
    if (late_q == LATE_CNT) begin
      set_vec = set_vec | hise_pkg::LATE_ONE_BITS;
    end
  end

  // ************************************************************
  // Event flags
  // ************************************************************
  logic [31:0] clr_vec;
  logic [31:0] flags_q;
  logic [31:0] flags_d;

  always_comb begin
    clr_vec = 32'h00000000;
    if (wr_flags) begin
      // Reserved positions ignore the write, so the late bits stay up.
      clr_vec = bus.wdata & hise_pkg::EVENT_BITS;
    end
    // A new event in the clearing cycle wins over the clear.
    flags_d = (flags_q & ~clr_vec) | set_vec;
  end

  // Software can never set a flag; only events do.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_q <= hise_pkg::FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ************************************************************
  // Event enables
  // ************************************************************
  logic [31:0] enables_q;
  logic [31:0] enables_d;

  // Enables are plain storage; the master gate is applied only at the line.
  always_comb begin
    enables_d = enables_q;
    if (wr_enables) begin
      // Reserved positions always read back zero.
      enables_d = bus.wdata & hise_pkg::EVENT_BITS;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      enables_q <= hise_pkg::ENABLES_RST;
    end else begin
      enables_q <= enables_d;
    end
  end

  // ************************************************************
  // Read-back
  // ************************************************************
  logic [31:0] rdata_d;

  // Idle cycles and unmapped addresses return zero.
  always_comb begin
    rdata_d = 32'h00000000;
    if (rd_flags) begin
      rdata_d = flags_q;
    end else if (rd_enables) begin
      rdata_d = enables_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rdata_d;
    end
  end

  // ************************************************************
  // Interrupt line
  // ************************************************************
  localparam int SRC_N = 7;
  logic [SRC_N-1:0] src_vec;
  logic irq_d;

  // The line is registered so it never glitches while flags and enables change together.
  always_comb begin
    src_vec[0] = flags_q[hise_pkg::ISO_BIT] & enables_q[hise_pkg::ISO_BIT];
    src_vec[1] = flags_q[hise_pkg::ASYNC_BIT] & enables_q[hise_pkg::ASYNC_BIT];
    src_vec[2] = flags_q[hise_pkg::INTL_BIT] & enables_q[hise_pkg::INTL_BIT];
    src_vec[3] = flags_q[hise_pkg::CLK_BIT] & enables_q[hise_pkg::CLK_BIT];
    src_vec[4] = flags_q[hise_pkg::SUSP_BIT] & enables_q[hise_pkg::SUSP_BIT];
    src_vec[5] = flags_q[hise_pkg::DMA_BIT] & enables_q[hise_pkg::DMA_BIT];
    src_vec[6] = flags_q[hise_pkg::SOF_BIT] & enables_q[hise_pkg::SOF_BIT];
    irq_d = master_irq_gate & (|src_vec);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // ************************************************************
  // Wake after suspend
  // ************************************************************
  logic wake_start;

  // A zero wake time cancels a running window and never opens one.
  always_comb begin
    wake_start = 1'b0;
    if (bus.sel && (bus.rd || bus.wr)) begin
      // Any access while the suspend flag stands restarts the wake window.
      wake_start = flags_q[hise_pkg::SUSP_BIT];
    end
  end

  hise_wake_timer #(.UNIT_CYC(hise_pkg::WAKE_UNIT_CYC)) u_wake (
    .clk(clk),
    .nrst(nrst),
    .start(wake_start),
    .wake_time(wake_time),
    .awake(wake_hold)
  );

endmodule

// file: verification/hise_monitor.sv
`timescale 1ns/10ps
module hise_monitor (
  input wire logic clk,
  input wire logic nrst,
  input hise_pkg::hise_bus_s bus,
  input hise_pkg::hise_evt_s evt,
  input wire logic master_irq_gate,
  input wire logic [15:0] wake_time,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic wake_hold
);
  logic [7:0] cyc_q;
  logic en_seen_q;
  logic rd_fl;
  logic rd_any;
  assign rd_fl = bus.sel && bus.rd && bus.addr == hise_pkg::FLAGS_OFS;
  assign rd_any = bus.sel && bus.rd && (rd_fl || bus.addr == hise_pkg::ENABLES_OFS);
  // Saturating age counter: the late bits are only judged well clear of their rise.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cyc_q <= 8'h00;
      en_seen_q <= 1'b0;
    end else begin
      if (cyc_q != 8'hFF) cyc_q <= cyc_q + 8'h01;
      if (bus.sel && bus.wr && bus.addr == hise_pkg::ENABLES_OFS && |(bus.wdata & hise_pkg::EVENT_BITS)) en_seen_q <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  irq_gate_a: assert property (!$past(master_irq_gate) |-> !irq) else $error("irq without gate");
  irq_enable_a: assert property (irq |-> en_seen_q) else $error("irq with no enable");
  late_zero_a: assert property ($past(rd_fl) && cyc_q < 8'h14 |-> (rdata & hise_pkg::LATE_ONE_BITS) == 32'h00000000)
    else $error("late bits set early");
  late_one_a: assert property ($past(rd_fl) && cyc_q > 8'h28 |-> (rdata & hise_pkg::LATE_ONE_BITS) == hise_pkg::LATE_ONE_BITS)
    else $error("late bits not set");
  resv_zero_a: assert property ($past(rd_any) |-> (rdata & ~(hise_pkg::EVENT_BITS | hise_pkg::LATE_ONE_BITS)) == 32'h00000000)
    else $error("reserved bits read nonzero");
  wake_cause_a: assert property ($rose(wake_hold) |-> $past(bus.sel && (bus.rd || bus.wr))) else $error("wake without access");
  wake_zero_a: assert property ($rose(wake_hold) |-> $past(wake_time) != 16'h0000) else $error("wake with zero time");
  sof_latch_a: assert property (evt.frame_start ##[1:4] rd_fl |=> rdata[hise_pkg::SOF_BIT]) else $error("frame flag lost");
  cover property ($rose(irq));
  cover property ($rose(wake_hold));
  cover property (evt.frame_start ##[1:4] rd_fl);
endmodule
bind hise_top hise_monitor u_mon (
  .clk(clk),
  .nrst(nrst),
  .bus(bus),
  .evt(evt),
  .master_irq_gate(master_irq_gate),
  .wake_time(wake_time),
  .rdata(rdata),
  .irq(irq),
  .wake_hold(wake_hold)
);

// file: verification/host_irq_status_enable_tb_top.sv
`timescale 1ns/10ps
module host_irq_status_enable_tb_top;
  localparam logic [15:0] FA = hise_pkg::FLAGS_OFS;
  localparam logic [15:0] EA = hise_pkg::ENABLES_OFS;
  localparam logic [31:0] LB = hise_pkg::LATE_ONE_BITS;
  logic clk;
  logic nrst;
  hise_pkg::hise_bus_s bus;
  hise_pkg::hise_list_s lst [3];
  hise_pkg::hise_evt_s evt;
  logic clocks_running;
  logic gate;
  logic [15:0] wake_time;
  logic [31:0] rdata;
  logic irq;
  logic wake_hold;
  logic pend;
  logic [31:0] b;
  logic [31:0] d;
  logic [15:0] a;
  int n;
  int miscompares;
  int checks_done;
  logic [31:0] expq [$];
  int fb [7] = '{hise_pkg::ISO_BIT, hise_pkg::ASYNC_BIT, hise_pkg::INTL_BIT, hise_pkg::CLK_BIT, hise_pkg::SUSP_BIT,
    hise_pkg::DMA_BIT, hise_pkg::SOF_BIT};
  hise_top u_dut (.clk(clk), .nrst(nrst), .bus(bus), .iso_list(lst[0]), .async_list(lst[1]), .intl_list(lst[2]),
    .evt(evt), .clocks_running(clocks_running), .master_irq_gate(gate), .wake_time(wake_time), .rdata(rdata),
    .irq(irq), .wake_hold(wake_hold));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic acc(logic w, logic [15:0] ad, logic [31:0] wd);
    @(negedge clk);
    bus = '{1'b1, w, !w, ad, wd};
    @(negedge clk);
    bus = '0;
  endtask
  task automatic rd(logic [15:0] ad, logic [31:0] e);
    expq.push_back(e);
    acc(1'b0, ad, 32'h00000000);
  endtask
  task automatic fire(int i, logic [31:0] dn);
    @(negedge clk);
    case (i)
      0, 1, 2: lst[i].done = dn;
      3: clocks_running = 1'b1;
      4: evt.suspend_entered = 1'b1;
      5: evt.dma_done = 1'b1;
      default: evt.frame_start = 1'b1;
    endcase
    @(negedge clk);
    evt = '0;
    for (int j = 0; j < 3; j++) lst[j].done = 32'h00000000;
    repeat ((i == 3) ? 8 : 2) @(negedge clk);
    clocks_running = 1'b0;
  endtask
  // ************************************************************
  // Read results are compared in the cycle after the request
  // ************************************************************
  always @(posedge clk) pend <= nrst && bus.sel && bus.rd;
  always @(negedge clk) begin
    if (pend) chk("rdata", rdata, expq.pop_front());
  end
  initial begin
    bus = '0;
    evt = '0;
    lst = '{default: '0};
    clocks_running = 1'b0;
    gate = 1'b0;
    wake_time = 16'h0000;
    nrst = 1'b0;
    miscompares = 0;
    checks_done = 0;
    void'($urandom(93));
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    rd(FA, 32'h00000000);
    rd(EA, 32'h00000000);
    repeat (40) @(negedge clk);
    acc(1'b1, FA, hise_pkg::EVENT_BITS);
    rd(FA, LB);
    d = $urandom & hise_pkg::EVENT_BITS;
    acc(1'b1, EA, d);
    a = 16'h0400 | 16'($urandom_range(255));
    acc(1'b1, a, 32'hFFFFFFFF);
    rd(a, 32'h00000000);
    rd(EA, d & hise_pkg::EVENT_BITS);
    for (int i = 0; i < 7; i++) begin
      b = 32'h1 << fb[i];
      acc(1'b1, EA, hise_pkg::EVENT_BITS & ~b);
      gate = 1'(i % 2);
      fire(i, 32'h1 << $urandom_range(31));
      rd(FA, LB | b);
      chk("irq", {31'h0, irq}, 32'h00000000);
      acc(1'b1, FA, b);
      rd(FA, LB);
      gate = 1'b0;
      acc(1'b1, EA, b);
      fire(i, 32'h1 << $urandom_range(31));
      repeat (2) @(negedge clk);
      chk("irq", {31'h0, irq}, 32'h00000000);
      acc(1'b1, FA, hise_pkg::EVENT_BITS & ~b);
      gate = 1'b1;
      repeat (2) @(negedge clk);
      chk("irq", {31'h0, irq}, 32'h00000001);
      acc(1'b1, FA, b);
      repeat (2) @(negedge clk);
      chk("irq", {31'h0, irq}, 32'h00000000);
    end
    for (int i = 0; i < 3; i++) begin
      b = 32'h1 << fb[i];
      lst[i].and_mask = 32'h00000003;
      fire(i, 32'h00000001);
      rd(FA, LB);
      fire(i, 32'h00000002);
      rd(FA, LB | b);
      acc(1'b1, FA, b);
      lst[i].or_mask = 32'h00000010;
      fire(i, 32'h00000200);
      rd(FA, LB);
      fire(i, 32'h00000010);
      rd(FA, LB | b);
      acc(1'b1, FA, b);
      lst[i] = '0;
    end
    wake_time = 16'($urandom_range(3, 1));
    fire(4, 32'h00000000);
    rd(FA, LB | 32'h00000020);
    n = 0;
    while (wake_hold && n < 1000) begin
      @(negedge clk);
      n++;
    end
    n = n - hise_pkg::WAKE_UNIT_CYC * int'(wake_time);
    chk("wake", 32'(n > -4 && n < 4), 32'h00000001);
    repeat (3) @(negedge clk);
    summarize();
  end
endmodule
